// ===== logic/periph_irq_ctrl.sv
`timescale 1ns/1ns
`include "periph_irq_params.svh"
module periph_irq_ctrl
  import periph_irq_pkg::*;
#(
  parameter bit HAS_SLAVE_PORT = 1'b1,
  parameter bit HAS_CONVERTER = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire src_bits_type src_set_i,
  input wire logic rx_data_read_i,
  input wire logic tx_data_write_i,
  output logic periph_irq_o,
  output logic irq_o
);

  // ****************************************************
  // Constants
  // ****************************************************

  // Sources that exist on this variant
  localparam src_bits_type PRESENT = src_bits_type'({
    HAS_SLAVE_PORT, HAS_CONVERTER, 6'h3f});
  localparam logic [7:0] WR_MASK = `FLAGS_WR_MASK;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ****************************************************
  // State
  // ****************************************************

  bus_state_type bus_state_ff;
  bus_state_type nxt_bus_state;
  src_bits_type flags_ff;
  src_bits_type enables_ff;
  src_bits_type evt_status_ff;
  src_bits_type evt_mask_ff;
  logic [7:0] core_ctrl_ff;
  logic [31:0] rdata_ff;
  logic ack_ff;
  logic periph_req_ff;
  logic irq_ff;
  src_bits_type nxt_flags;
  src_bits_type nxt_enables;
  src_bits_type nxt_evt_status;
  src_bits_type nxt_evt_mask;
  logic [7:0] nxt_core_ctrl;

  // ****************************************************
  // Bus decode
  // ****************************************************

  // A request is taken once, on the edge that raises ack
  wire req_take = cyc_i & stb_i & (bus_state_ff == BUS_IDLE);
  wire wr_lane = req_take & we_i & sel_i[0];
  wire rd_take = req_take & ~we_i;
  wire hit_flags = (adr_i == `FLAGS_OFS);
  wire hit_enables = (adr_i == `ENABLES_OFS);
  wire hit_core = (adr_i == `CORE_CTRL_OFS);
  wire hit_status = (adr_i == `EVT_STATUS_OFS);
  wire hit_mask = (adr_i == `EVT_MASK_OFS);
  wire wr_flags = wr_lane & hit_flags;
  wire wr_enables = wr_lane & hit_enables;
  wire wr_core = wr_lane & hit_core;
  wire wr_mask = wr_lane & hit_mask;
  wire rd_status = rd_take & hit_status;
  wire [7:0] wbyte = dat_i[7:0];

  // Unmapped addresses answer with zero and drop writes
  wire [7:0] rd_byte =
    hit_flags ? flags_ff :
    hit_enables ? enables_ff :
    hit_core ? core_ctrl_ff :
    hit_status ? evt_status_ff :
    hit_mask ? evt_mask_ff : 8'h00;

  // Bus state machine: one wait state, then ack for a cycle
  always_comb begin
    nxt_bus_state = bus_state_ff;
    unique case (bus_state_ff)
      BUS_IDLE: begin
        if (req_take) begin
          nxt_bus_state = BUS_ACK;
        end
      end
      BUS_ACK: begin
        nxt_bus_state = BUS_IDLE;
      end
      default: begin
        nxt_bus_state = BUS_IDLE;
      end
    endcase
  end

  // ****************************************************
  // Source events
  // ****************************************************

  // Events are masked to present sources so absent bits stay 0
  wire [7:0] set_ev = src_set_i & PRESENT;

  // Hardware clears only for the two serial flags
  wire [7:0] hw_clr = {2'b00, rx_data_read_i, tx_data_write_i,
    4'h0};

  // ****************************************************
  // Flag update, one slice per source
  // ****************************************************

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      // Set wins over any clear in the same cycle
      always_comb begin
        if (set_ev[gi]) begin
          nxt_flags[gi] = 1'b1;
        end else if (wr_flags & WR_MASK[gi]) begin
          nxt_flags[gi] = wbyte[gi] & PRESENT[gi];
        end else if (hw_clr[gi]) begin
          nxt_flags[gi] = 1'b0;
        end else begin
          nxt_flags[gi] = flags_ff[gi];
        end
      end

      // Enable bit, one per source in fixed order
      always_comb begin
        if (wr_enables) begin
          nxt_enables[gi] = wbyte[gi] & PRESENT[gi];
        end else begin
          nxt_enables[gi] = enables_ff[gi];
        end
      end

      // Sticky event status; a read clears, a new event wins
      always_comb begin
        if (set_ev[gi]) begin
          nxt_evt_status[gi] = 1'b1;
        end else if (rd_status) begin
          nxt_evt_status[gi] = 1'b0;
        end else begin
          nxt_evt_status[gi] = evt_status_ff[gi];
        end
      end

      // Mask uses the same layout as the status
      always_comb begin
        if (wr_mask) begin
          nxt_evt_mask[gi] = wbyte[gi];
        end else begin
          nxt_evt_mask[gi] = evt_mask_ff[gi];
        end
      end
    end
  endgenerate

  // Core control holds only the global and gate bits
  assign nxt_core_ctrl = wr_core ?
    (wbyte & `CORE_CTRL_MASK) : core_ctrl_ff;

  // ****************************************************
  // Request logic
  // ****************************************************

  wire global_en = core_ctrl_ff[`BIT_GLOBAL_EN];
  wire gate_en = core_ctrl_ff[`BIT_GATE_EN];
  // Each source passes only with its own enable set
  wire [7:0] pend = flags_ff & enables_ff;
  // Gate and global enable block every source of periph_irq_o when clear
  wire nxt_periph_req = (|pend) & gate_en & global_en;
  wire nxt_irq = |(evt_status_ff & evt_mask_ff);

  // ****************************************************
  // Registers
  // ****************************************************

  // Bus slave registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_ff <= BUS_IDLE;
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      bus_state_ff <= nxt_bus_state;
      ack_ff <= req_take;
      rdata_ff <= rd_take ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Register file; all cleared at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_ff <= `FLAGS_RST;
      enables_ff <= `ENABLES_RST;
      core_ctrl_ff <= `CORE_CTRL_RST;
      evt_status_ff <= `EVT_RST;
      evt_mask_ff <= `EVT_RST;
    end else begin
      flags_ff <= nxt_flags;
      enables_ff <= nxt_enables;
      core_ctrl_ff <= nxt_core_ctrl;
      evt_status_ff <= nxt_evt_status;
      evt_mask_ff <= nxt_evt_mask;
    end
  end

  // Interrupt outputs registered so they leave from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph_req_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      periph_req_ff <= nxt_periph_req;
      irq_ff <= nxt_irq;
    end
  end

  assign dat_o = rdata_ff;
  assign ack_o = ack_ff;
  assign periph_irq_o = periph_req_ff;
  assign irq_o = irq_ff;

  // ****************************************************
  // Checks
  // ****************************************************

  // Software side ordering is not checked in hardware
  // Stale flags would fire at once when enabled

  sequence s_flag_pending(int b);
    flags_ff[b] && enables_ff[b];
  endsequence

  // Both core gates open, so a pending source must get through
  sequence s_gates_open;
    gate_en && global_en;
  endsequence

  a_gate_blocks_req:
    assert property (!gate_en |=> !periph_irq_o)
    else $error("request while gate bit clear");

  a_global_blocks_req:
    assert property (!global_en |=> !periph_irq_o)
    else $error("request while global enable clear");

  a_req_from_pend:
    assert property (
      (s_flag_pending(`BIT_TIMER_ONE) and (gate_en && global_en))
      |=> periph_irq_o)
    else $error("pending timer one source gave no request");

  a_conv_passes:
    assert property (
      (s_flag_pending(`BIT_CONVERTER) and s_gates_open) |=> periph_irq_o)
    else $error("pending converter source gave no request");

  a_rx_src_passes:
    assert property (
      (s_flag_pending(`BIT_SERIAL_RX) and s_gates_open) |=> periph_irq_o)
    else $error("pending receive source gave no request");

  a_tx_src_passes:
    assert property (
      (s_flag_pending(`BIT_SERIAL_TX) and s_gates_open) |=> periph_irq_o)
    else $error("pending transmit source gave no request");

  a_timer_two_passes:
    assert property (
      (s_flag_pending(`BIT_TIMER_TWO) and s_gates_open) |=> periph_irq_o)
    else $error("pending timer two source gave no request");

  a_timer_one_blocked:
    assert property ((((flags_ff & enables_ff & 8'hfe) == 8'h00)
      && !enables_ff[`BIT_TIMER_ONE]) |=> !periph_irq_o)
    else $error("request with timer one disabled");

  // A raised slave port flag alone must not reach the request
  a_disabled_src_quiet:
    assert property ((((flags_ff & enables_ff & 8'h7f) == 8'h00)
      && !enables_ff[`BIT_SLAVE_PORT]) |=> !periph_irq_o)
    else $error("request with slave port disabled");

  a_flag_sets_always:
    assert property (src_set_i.capcomp_one |=> flags_ff[`BIT_CAPCOMP_ONE])
    else $error("flag missed its set event");

  a_rx_flag_readonly:
    assert property ((wr_flags && !set_ev[`BIT_SERIAL_RX]
      && !rx_data_read_i) |=>
      flags_ff[`BIT_SERIAL_RX] == $past(flags_ff[`BIT_SERIAL_RX]))
    else $error("software changed receive flag");

  a_tx_flag_clear:
    assert property ((tx_data_write_i && !set_ev[`BIT_SERIAL_TX])
      |=> !flags_ff[`BIT_SERIAL_TX])
    else $error("transmit flag not cleared by data write");

  a_enable_write:
    assert property (wr_enables |=> enables_ff == (wbyte & PRESENT))
    else $error("enable register write lost");

  a_flag_holds:
    assert property ((flags_ff[`BIT_TIMER_TWO] && !wr_flags)
      |=> flags_ff[`BIT_TIMER_TWO])
    else $error("writable flag cleared by hardware");

  a_absent_zero:
    assert property ((!PRESENT[`BIT_CONVERTER]) |->
      (!flags_ff[`BIT_CONVERTER] && !enables_ff[`BIT_CONVERTER]))
    else $error("absent converter bit set");

  a_absent_port_zero:
    assert property ((!PRESENT[`BIT_SLAVE_PORT]) |->
      (!flags_ff[`BIT_SLAVE_PORT] && !enables_ff[`BIT_SLAVE_PORT]))
    else $error("absent slave port bit set");

  // A status read empties the register unless an event lands
  a_status_read_clear:
    assert property ((rd_status && (set_ev == 8'h00)) |=>
      (evt_status_ff == 8'h00))
    else $error("event status not cleared by read");

  a_enable_decode:
    assert property ((rd_take && hit_enables) |=>
      ack_o && dat_o[7:0] == $past(enables_ff))
    else $error("enable register not read at its address");

  a_ack_one_cycle:
    assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

endmodule // periph_irq_ctrl

// ===== logic/periph_irq_params.svh
`ifndef PERIPH_IRQ_PARAMS_SVH
`define PERIPH_IRQ_PARAMS_SVH

// Byte offsets on the register bus
`define FLAGS_OFS 8'h0c
`define ENABLES_OFS 8'h8c
`define CORE_CTRL_OFS 8'h10
`define EVT_STATUS_OFS 8'h14
`define EVT_MASK_OFS 8'h18

// Bit positions inside the source byte
`define BIT_SLAVE_PORT 7
`define BIT_CONVERTER 6
`define BIT_SERIAL_RX 5
`define BIT_SERIAL_TX 4
`define BIT_SYNC_SERIAL 3
`define BIT_CAPCOMP_ONE 2
`define BIT_TIMER_TWO 1
`define BIT_TIMER_ONE 0

// Bit positions inside the core control byte
`define BIT_GLOBAL_EN 7
`define BIT_GATE_EN 6

// Reset values
`define FLAGS_RST 8'h00
`define ENABLES_RST 8'h00
`define CORE_CTRL_RST 8'h00
`define EVT_RST 8'h00

// Flag bits that software may write
`define FLAGS_WR_MASK 8'hcf
// Core control bits that exist
`define CORE_CTRL_MASK 8'hc0

`endif

// ===== logic/periph_irq_pkg.sv
package periph_irq_pkg;

  // One bit per peripheral source, bit 7 first
  typedef struct packed {
    logic slave_port;
    logic converter;
    logic serial_rx;
    logic serial_tx;
    logic sync_serial;
    logic capcomp_one;
    logic timer_two_match;
    logic timer_one_overflow;
  } src_bits_type;

  // Register bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_type;

endpackage

// ===== dv/periph_src_model.sv
`timescale 1ns/1ns
// Peripheral side: turns bench requests into set and clear pulses
module periph_src_model
  import periph_irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire src_bits_type req_i,
  input wire logic rx_rd_i,
  input wire logic tx_wr_i,
  output src_bits_type src_set_o,
  output logic rx_data_read_o,
  output logic tx_data_write_o
);
  // Registered, so each pulse follows its request one core clock later and lasts as long
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_set_o <= '0;
      rx_data_read_o <= 1'b0;
      tx_data_write_o <= 1'b0;
    end else begin
      src_set_o <= req_i;
      rx_data_read_o <= rx_rd_i;
      tx_data_write_o <= tx_wr_i;
    end
  end
endmodule // periph_src_model

// ===== dv/periph_irq_ctrl_tb_top.sv
`timescale 1ns/1ns
`include "periph_irq_params.svh"
module periph_irq_ctrl_tb_top
  import periph_irq_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic rx_req = 1'b0;
  logic tx_req = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] b;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic [31:0] dat_lite;
  logic [31:0] rd_lite;
  logic irq_lite;
  logic ack_o, periph_irq_o, irq_o, rx_rd, tx_wr;
  src_bits_type src_req = '0;
  src_bits_type src_set;
  int n_errors = 0;
  int samples_checked = 0;

  // 100 MHz core clock
  always #5 clk_i = ~clk_i;

  periph_irq_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack_o), .src_set_i(src_set),
    .rx_data_read_i(rx_rd), .tx_data_write_i(tx_wr),
    .periph_irq_o(periph_irq_o), .irq_o(irq_o));

  // Variant with neither slave port nor converter fitted
  periph_irq_ctrl #(.HAS_SLAVE_PORT(1'b0), .HAS_CONVERTER(1'b0)) uut_lite (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'h1), .dat_i(dat), .dat_o(dat_lite), .ack_o(),
    .src_set_i(src_set), .rx_data_read_i(rx_rd), .tx_data_write_i(tx_wr),
    .periph_irq_o(irq_lite), .irq_o());

  periph_src_model far (.clk_i(clk_i), .rst_i(rst_i), .req_i(src_req),
    .rx_rd_i(rx_req), .tx_wr_i(tx_req), .src_set_o(src_set),
    .rx_data_read_o(rx_rd), .tx_data_write_o(tx_wr));

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task finish_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  // Classic cycle; request held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      n_errors++;
      finish_test();
    end
    rd = dat_o;
    rd_lite = dat_lite;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // One source event, then time for flag and request to settle
  task fire(input logic [7:0] s);
    @(posedge clk_i);
    src_req <= src_bits_type'(s);
    @(posedge clk_i);
    src_req <= '0;
    wt(3);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    wt(10);
    rst_i <= 1'b0;
    wb(0, `FLAGS_OFS, 0);
    chk("flags reset", 0, rd);
    wb(0, `ENABLES_OFS, 0);
    chk("enables reset", 0, rd);
    wb(1, `ENABLES_OFS, 8'ha5);
    wb(0, `ENABLES_OFS, 0);
    chk("enables rw", 32'ha5, rd);
    chk("absent enables", 32'h25, rd_lite);
    wb(1, `FLAGS_OFS, 8'hff);
    wb(0, `FLAGS_OFS, 0);
    chk("flags rw", 32'hcf, rd);
    chk("absent flags", 32'h0f, rd_lite);
    wb(1, 8'h40, 8'hff);
    wb(0, 8'h40, 0);
    chk("unmapped", 0, rd);
    // Stale flags cleared before any source is enabled
    wb(1, `ENABLES_OFS, 0);
    wb(1, `FLAGS_OFS, 0);
    for (int i = 0; i < 8; i++) begin
      b = 8'h01 << i;
      fire(b);
      wb(0, `FLAGS_OFS, 0);
      chk("flag set", {24'h0, b}, rd);
      chk("absent flag", {24'h0, b & 8'h3f}, rd_lite);
      chk("irq disabled", 0, periph_irq_o);
      wb(1, `ENABLES_OFS, b);
      wb(1, `CORE_CTRL_OFS, 8'h40);
      wt(2);
      chk("no global", 0, periph_irq_o);
      wb(1, `CORE_CTRL_OFS, 8'h80);
      wt(2);
      chk("no gate", 0, periph_irq_o);
      wb(1, `CORE_CTRL_OFS, 8'hc0);
      wt(2);
      chk("irq on", 1, periph_irq_o);
      chk("lite irq", {31'h0, i < 6}, irq_lite);
      wb(1, `ENABLES_OFS, 0);
      wt(2);
      chk("irq off", 0, periph_irq_o);
      // Serial flags only clear through their data register access
      if (i == 4 || i == 5) begin
        @(posedge clk_i);
        tx_req <= (i == 4);
        rx_req <= (i == 5);
        @(posedge clk_i);
        tx_req <= 1'b0;
        rx_req <= 1'b0;
        wt(2);
      end else
        wb(1, `FLAGS_OFS, 0);
      wb(1, `CORE_CTRL_OFS, 0);
      wb(0, `FLAGS_OFS, 0);
      chk("flag clear", 0, rd);
    end
    // Event status is sticky, cleared by a read, gated by the mask
    wb(1, `EVT_MASK_OFS, 8'h02);
    wt(2);
    chk("evt irq", 1, irq_o);
    wb(0, `EVT_STATUS_OFS, 0);
    chk("evt status", 32'hff, rd);
    chk("absent evt", 32'h3f, rd_lite);
    wt(2);
    chk("evt irq clr", 0, irq_o);
    fire(8'h01);
    chk("evt masked", 0, irq_o);
    wb(1, `EVT_MASK_OFS, 8'h01);
    wt(2);
    chk("evt unmask", 1, irq_o);
    wb(0, `EVT_STATUS_OFS, 0);
    chk("evt one", 32'h01, rd);
    finish_test();
  end

  // Watchdog: a hang counts as a mismatch
  initial begin
    wt(5000);
    n_errors++;
    finish_test();
  end
endmodule // periph_irq_ctrl_tb_top
